// file: inc/timer_pair_pkg.sv
// constants for the timer pair joint control block
// assumes an 8-bit register file port with 12-bit linear addresses
package timer_pair_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] MODE_CTRL_ADDR = 12'h0D01;
    localparam logic [11:0] ENV_CTRL_ADDR = 12'h0D02;
    localparam logic [11:0] JOINT_CTRL_ADDR = 12'h0D03;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h0D04;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h0D05;
    localparam int ENV_RUN_BIT = 7;
    localparam int CAR_RUN_BIT = 6;
    localparam int SYNC_BIT = 5;
    localparam int INHIBIT_BIT = 4;
    localparam int ONE_CYCLE_BIT = 3;
    localparam int DEMOD_BIT = 7;
    localparam int TIMEOUT_BIT = 5;
    localparam int EV_ENV_TIMEOUT = 0;
    localparam int EV_CAR_CAPTURE = 1;
    localparam int IRQ_W = 2;
    localparam logic [2:0] JOINT_LOW_READ = 3'h7;
    localparam logic [4:0] JOINT_RESET = 5'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] EDGE_ACTIVE = 3'h3;
    localparam logic [2:0] EDGE_CAP_FIRST = 3'h4;
    localparam logic [2:0] EDGE_CAP_LAST = 3'h5;
    localparam logic [2:0] EDGE_ZERO = 3'h0;
    localparam logic [2:0] EDGE_ONE = 3'h1;
endpackage : timer_pair_pkg

// file: rtl/timer_pair_ctrl.sv
// joint control of the carrier and envelope timers, with capture sequencing
// assumes timer strobes come from logic on sys_clk; the capture pin is asynchronous
// Behaviour
// R1 - separate run bits start each timer
// R2 - sync mode aligns first carrier pulse
// R3 - sync bit survives stop-mode recovery
// R4 - inhibit holds envelope output at terminal count
// R5 - time-out still flagged; inhibit survives recovery
// R6 - one-cycle capture bit survives recovery
// R7 - capture bit clear: capture every edge
// R8 - active third edge, capture fourth fifth
// R9 - carrier time-out resets edge count
// R10 - low three bits read ones, ignore writes
// R11 - joint register at linear address D03h
// R12 - mode bit selects transmit or demodulation
// R13 - terminal count sets flag, write one clears
// R14 - full reset clears all joint bits
// R15 - joint bits are plain read/write storage
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module timer_pair_ctrl
    import timer_pair_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stop_recovery,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic envelope_tc,
    input wire logic carrier_tc,
    input wire logic capture_pin,
    output logic envelope_timer_run,
    output logic carrier_timer_run,
    output logic carrier_count_go,
    output logic carrier_sync_load,
    output logic envelope_out,
    output logic carrier_active,
    output logic carrier_capture,
    output logic irq
);
    logic [4:0] joint_ff;
    logic demod_ff;
    logic [IRQ_W-1:0] status_ff;
    logic [IRQ_W-1:0] mask_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic env_run_d_ff;
    logic go_ff;
    logic load_ff;
    logic env_out_ff;
    logic active_ff;
    logic capture_ff;
    logic irq_ff;
    logic pin_s1_ff;
    logic pin_s2_ff;
    logic pin_s3_ff;
    logic pin_level_ff;
    logic [2:0] edge_cnt_ff;
    logic [4:0] nxt_joint;
    logic [IRQ_W-1:0] nxt_status;
    logic [2:0] nxt_edge_cnt;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction : hit

    // R11 - joint register decode
    wire wr_joint = reg_wr && hit(reg_addr, JOINT_CTRL_ADDR);
    wire wr_mode = reg_wr && hit(reg_addr, MODE_CTRL_ADDR);
    wire wr_env = reg_wr && hit(reg_addr, ENV_CTRL_ADDR);
    wire wr_stat = reg_wr && hit(reg_addr, IRQ_STATUS_ADDR);
    wire wr_mask = reg_wr && hit(reg_addr, IRQ_MASK_ADDR);
    wire env_run = joint_ff[ENV_RUN_BIT-3];
    wire car_run = joint_ff[CAR_RUN_BIT-3];
    wire sync_mode = joint_ff[SYNC_BIT-3];
    wire inhibit = joint_ff[INHIBIT_BIT-3];
    wire one_cycle = joint_ff[ONE_CYCLE_BIT-3];

    // R15 - plain storage; R3 R5 R6 - recovery clears only the run bits
    // R10 - low bits are not stored, so writes to them vanish
    assign nxt_joint = wr_joint ? reg_wdata[7:3] :
        stop_recovery ? {2'b00, joint_ff[2:0]} : joint_ff;

    // R2 - carrier waits for an envelope start or terminal count
    wire env_start = env_run && !env_run_d_ff;
    wire env_align = env_start || (env_run && envelope_tc);
    wire nxt_go = car_run && (!sync_mode || go_ff || env_align);
    wire nxt_load = car_run && sync_mode && !go_ff && env_align;

    // R4 - toggle only while not inhibited
    wire nxt_env_out = (envelope_tc && !inhibit) ? !env_out_ff : env_out_ff;

    // accepted pin change once the second and third stages agree
    wire pin_stable = pin_s2_ff == pin_s3_ff;
    wire pin_edge = pin_stable && (pin_s3_ff != pin_level_ff);
    wire capture_on = demod_ff && car_run;
    wire edge_seen = capture_on && pin_edge;

    // R9 - time-out restarts the edge sequence
    // R8 - count edges up to the fifth, then hold
    assign nxt_edge_cnt = (carrier_tc && one_cycle) ? EDGE_ZERO :
        (edge_seen && one_cycle && edge_cnt_ff != EDGE_CAP_LAST) ?
        edge_cnt_ff + EDGE_ONE : edge_cnt_ff;
    wire cnt_cap = (nxt_edge_cnt == EDGE_CAP_FIRST) || (nxt_edge_cnt == EDGE_CAP_LAST);
    wire cnt_moved = nxt_edge_cnt != edge_cnt_ff;
    // R12 R7 - ordinary demodulation captures every edge
    wire nxt_capture = edge_seen && (one_cycle ? (cnt_moved && cnt_cap) : 1'b1);
    wire nxt_active = one_cycle ? (nxt_edge_cnt >= EDGE_ACTIVE) : capture_on;
    wire cap_irq = edge_seen && (one_cycle ?
        (cnt_moved && nxt_edge_cnt == EDGE_CAP_LAST) : 1'b1);

    // R13 R5 - time-out flagged whatever the inhibit; set wins over clear
    wire [IRQ_W-1:0] ev_set = {cap_irq, envelope_tc};
    wire [IRQ_W-1:0] ev_clr_stat = wr_stat ? reg_wdata[IRQ_W-1:0] : IRQ_RESET;
    wire [IRQ_W-1:0] ev_clr_env = {1'b0, wr_env && reg_wdata[TIMEOUT_BIT]};
    assign nxt_status = (status_ff & ~(ev_clr_stat | ev_clr_env)) | ev_set;
    wire nxt_irq = |(nxt_status & mask_ff);

    wire [DATA_W-1:0] rd_joint = {joint_ff, JOINT_LOW_READ};
    wire [DATA_W-1:0] rd_mode = {demod_ff, 7'h00};
    wire [DATA_W-1:0] rd_env = {env_run, 1'b0, status_ff[EV_ENV_TIMEOUT], 5'h00};
    wire [DATA_W-1:0] rd_stat = {6'h00, status_ff};
    wire [DATA_W-1:0] rd_mask = {6'h00, mask_ff};
    wire [DATA_W-1:0] rd_mux =
        hit(reg_addr, JOINT_CTRL_ADDR) ? rd_joint :
        hit(reg_addr, MODE_CTRL_ADDR) ? rd_mode :
        hit(reg_addr, ENV_CTRL_ADDR) ? rd_env :
        hit(reg_addr, IRQ_STATUS_ADDR) ? rd_stat :
        hit(reg_addr, IRQ_MASK_ADDR) ? rd_mask : BYTE_ZERO;
    wire [DATA_W-1:0] nxt_rdata = reg_rd ? rd_mux : BYTE_ZERO;

    // R14 - full reset clears every joint bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            joint_ff <= JOINT_RESET;
            demod_ff <= 1'b0;
            mask_ff <= IRQ_RESET;
        end else begin
            joint_ff <= nxt_joint;
            demod_ff <= wr_mode ? reg_wdata[DEMOD_BIT] : demod_ff;
            mask_ff <= wr_mask ? reg_wdata[IRQ_W-1:0] : mask_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_ff <= IRQ_RESET;
            irq_ff <= 1'b0;
            rdata_ff <= BYTE_ZERO;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    // R1 - run outputs follow the enable bits, the carrier only after alignment in sync mode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            env_run_d_ff <= 1'b0;
            go_ff <= 1'b0;
            load_ff <= 1'b0;
            env_out_ff <= 1'b0;
        end else begin
            env_run_d_ff <= env_run;
            go_ff <= nxt_go;
            load_ff <= nxt_load;
            env_out_ff <= nxt_env_out;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_s3_ff <= 1'b0;
            pin_level_ff <= 1'b0;
        end else begin
            pin_s1_ff <= capture_pin;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_level_ff <= pin_stable ? pin_s3_ff : pin_level_ff;
        end
    end

    // a capture disabled mid-sequence keeps its count until a time-out
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            edge_cnt_ff <= EDGE_ZERO;
            active_ff <= 1'b0;
            capture_ff <= 1'b0;
        end else begin
            edge_cnt_ff <= nxt_edge_cnt;
            active_ff <= nxt_active;
            capture_ff <= nxt_capture;
        end
    end

    assign reg_rdata = rdata_ff;
    assign envelope_timer_run = env_run_d_ff;
    assign carrier_timer_run = go_ff;
    assign carrier_count_go = go_ff;
    assign carrier_sync_load = load_ff;
    assign envelope_out = env_out_ff;
    assign carrier_active = active_ff;
    assign carrier_capture = capture_ff;
    assign irq = irq_ff;

    sequence seq_write_joint;
        reg_wr && hit(reg_addr, JOINT_CTRL_ADDR);
    endsequence

    sequence seq_read_joint;
        reg_rd && hit(reg_addr, JOINT_CTRL_ADDR);
    endsequence

    chk_low_bits_ones: assert property ( // R10
        @(posedge sys_clk) disable iff (!rst_n)
        seq_read_joint |=> reg_rdata[2:0] == JOINT_LOW_READ)
        else $error("joint low bits did not read as ones");

    chk_joint_readback: assert property ( // R15
        @(posedge sys_clk) disable iff (!rst_n)
        seq_write_joint ##1 seq_read_joint |=> reg_rdata[7:3] == $past(reg_wdata[7:3], 2))
        else $error("joint register read back differs from write");

    chk_env_run_start: assert property ( // R1
        @(posedge sys_clk) disable iff (!rst_n)
        seq_write_joint ##0 reg_wdata[ENV_RUN_BIT] |=> ##1 envelope_timer_run)
        else $error("envelope timer did not start");

    chk_toggle_inhibit: assert property ( // R4
        @(posedge sys_clk) disable iff (!rst_n)
        envelope_tc && inhibit |=> $stable(envelope_out))
        else $error("envelope output toggled while inhibited");

    chk_toggle_normal: assert property ( // R4
        @(posedge sys_clk) disable iff (!rst_n)
        envelope_tc && !inhibit |=> envelope_out != $past(envelope_out))
        else $error("envelope output failed to toggle");

    chk_timeout_flag: assert property ( // R13
        @(posedge sys_clk) disable iff (!rst_n)
        envelope_tc && !wr_mask |=> status_ff[EV_ENV_TIMEOUT] &&
        (irq || !mask_ff[EV_ENV_TIMEOUT]))
        else $error("time-out flag or interrupt missing");

    chk_recovery_keeps: assert property ( // R6
        @(posedge sys_clk) disable iff (!rst_n)
        stop_recovery && !reg_wr |=> $stable(joint_ff[2:0]) && !joint_ff[4] && !joint_ff[3])
        else $error("stop recovery changed kept bits");

    chk_fifth_edge: assert property ( // R8
        @(posedge sys_clk) disable iff (!rst_n)
        edge_seen && one_cycle && !carrier_tc && edge_cnt_ff == EDGE_CAP_FIRST
        |=> carrier_capture && status_ff[EV_CAR_CAPTURE] && carrier_active)
        else $error("fifth edge not captured");

    chk_timeout_clears: assert property ( // R9
        @(posedge sys_clk) disable iff (!rst_n)
        carrier_tc && one_cycle |=> edge_cnt_ff == EDGE_ZERO && !carrier_capture)
        else $error("carrier time-out did not clear edge count");

    chk_sync_wait: assert property ( // R2
        @(posedge sys_clk) disable iff (!rst_n)
        sync_mode && !go_ff && !env_align |=> !carrier_count_go)
        else $error("carrier started before envelope alignment");

    sequence seq_one_cycle_edge;
        edge_seen && one_cycle && !carrier_tc;
    endsequence

    chk_fourth_edge: assert property ( // R8
        @(posedge sys_clk) disable iff (!rst_n)
        seq_one_cycle_edge ##0 edge_cnt_ff == EDGE_ACTIVE
        |=> carrier_capture && edge_cnt_ff == EDGE_CAP_FIRST)
        else $error("fourth edge not captured");

    chk_active_third: assert property ( // R8
        @(posedge sys_clk) disable iff (!rst_n)
        one_cycle && nxt_edge_cnt == EDGE_ACTIVE |=> carrier_active && !carrier_capture)
        else $error("carrier not active at third edge");

    chk_normal_capture: assert property ( // R7
        @(posedge sys_clk) disable iff (!rst_n)
        edge_seen && !one_cycle |=> carrier_capture && status_ff[EV_CAR_CAPTURE])
        else $error("ordinary capture missed an edge");

    chk_transmit_quiet: assert property ( // R12
        @(posedge sys_clk) disable iff (!rst_n)
        !demod_ff |=> !carrier_capture)
        else $error("capture seen in transmit operation");

    chk_set_wins: assert property ( // R13
        @(posedge sys_clk) disable iff (!rst_n)
        envelope_tc && wr_stat && reg_wdata[EV_ENV_TIMEOUT] |=> status_ff[EV_ENV_TIMEOUT])
        else $error("status clear beat a same-cycle event");

    chk_sync_kept: assert property ( // R3
        @(posedge sys_clk) disable iff (!rst_n)
        stop_recovery && !wr_joint |=> sync_mode == $past(sync_mode))
        else $error("sync mode changed by stop recovery");

    chk_reset_clears: assert property ( // R14
        @(posedge sys_clk)
        !rst_n |=> joint_ff == JOINT_RESET && !envelope_timer_run && !carrier_count_go && !irq)
        else $error("full reset left joint state set");
endmodule : timer_pair_ctrl

// file: test/timer_pair_ctrl_tb.sv
// self-checking bench for the timer pair joint control block
// assumes one 100 MHz clock and a register port with read data one cycle late
`timescale 1ns/1ps
module timer_pair_ctrl_tb;
    import timer_pair_pkg::*;
    logic sys_clk, rst_n, stop_recovery, reg_wr, reg_rd, envelope_tc, carrier_tc, capture_pin;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic envelope_timer_run, carrier_timer_run, carrier_count_go, carrier_sync_load;
    logic envelope_out, carrier_active, carrier_capture, irq;
    int miscompares = 0;
    int samples_checked = 0;
    int cap_cnt = 0;
    int sync_cnt = 0;
    timer_pair_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .stop_recovery(stop_recovery),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .envelope_tc(envelope_tc), .carrier_tc(carrier_tc),
        .capture_pin(capture_pin), .envelope_timer_run(envelope_timer_run),
        .carrier_timer_run(carrier_timer_run), .carrier_count_go(carrier_count_go),
        .carrier_sync_load(carrier_sync_load), .envelope_out(envelope_out),
        .carrier_active(carrier_active), .carrier_capture(carrier_capture), .irq(irq));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // pulse counters: one-cycle outputs are counted where they stand
    always @(posedge sys_clk) begin
        if (carrier_capture === 1'b1) cap_cnt++;
        if (carrier_sync_load === 1'b1) sync_cnt++;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : wr_rd
    task automatic pulse(input int which);
        @(posedge sys_clk);
        if (which == 0) envelope_tc <= 1'b1; else carrier_tc <= 1'b1;
        @(posedge sys_clk);
        envelope_tc <= 1'b0;
        carrier_tc <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
    // slow pin edges leave room for the synchroniser
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            capture_pin <= ~capture_pin;
            repeat (8) @(posedge sys_clk);
        end
    endtask : edges
    task automatic test_regs();
        rd(JOINT_CTRL_ADDR); check("joint reset", rd_val, 8'h07);
        check("run after reset", {6'h00, envelope_timer_run, carrier_timer_run}, 8'h00);
        wr_rd(JOINT_CTRL_ADDR, 8'h38);
        check("joint rw", rd_val, 8'h3F);
        wr(JOINT_CTRL_ADDR, 8'h00); rd(JOINT_CTRL_ADDR); check("low bits", rd_val, 8'h07);
        rd(12'h0D07); check("unmapped", rd_val, 8'h00);
        $display("test regs done");
    endtask : test_regs
    task automatic test_run_recovery();
        wr(JOINT_CTRL_ADDR, 8'hC0);
        repeat (2) @(posedge sys_clk);
        #1 check("both run", {6'h00, envelope_timer_run, carrier_count_go}, 8'h03);
        wr(JOINT_CTRL_ADDR, 8'h40); repeat (2) @(posedge sys_clk);
        #1 check("carrier only", {6'h00, envelope_timer_run, carrier_timer_run}, 8'h01);
        wr(JOINT_CTRL_ADDR, 8'hF8);
        @(posedge sys_clk); stop_recovery <= 1'b1;
        @(posedge sys_clk); stop_recovery <= 1'b0;
        rd(JOINT_CTRL_ADDR); check("after recovery", rd_val, 8'h3F);
        wr(JOINT_CTRL_ADDR, 8'h00);
        sync_cnt = 0;
        wr(JOINT_CTRL_ADDR, 8'hE0); repeat (3) @(posedge sys_clk);
        #1 check("sync load", 8'(sync_cnt), 8'h01);
        check("sync go", {7'h00, carrier_count_go}, 8'h01);
        // envelope already running: the carrier waits for a terminal count
        wr(JOINT_CTRL_ADDR, 8'h80);
        wr(JOINT_CTRL_ADDR, 8'hF0);
        repeat (2) @(posedge sys_clk);
        #1 check("sync waits", {7'h00, carrier_count_go}, 8'h00);
        sync_cnt = 0;
        pulse(0);
        check("sync on tc", {7'h00, carrier_count_go}, 8'h01);
        check("sync load tc", 8'(sync_cnt), 8'h01);
        wr(IRQ_STATUS_ADDR, 8'h01);
        wr(JOINT_CTRL_ADDR, 8'h00);
        $display("test run and recovery done");
    endtask : test_run_recovery
    task automatic test_envelope();
        wr(IRQ_MASK_ADDR, 8'h03);
        wr(JOINT_CTRL_ADDR, 8'h80);
        pulse(0); check("toggle", {7'h00, envelope_out}, 8'h01);
        check("irq up", {7'h00, irq}, 8'h01);
        rd(ENV_CTRL_ADDR); check("timeout flag", rd_val, 8'hA0);
        wr(ENV_CTRL_ADDR, 8'h20); rd(ENV_CTRL_ADDR); check("flag clear", rd_val, 8'h80);
        wr(IRQ_STATUS_ADDR, 8'h01); repeat (2) @(posedge sys_clk);
        #1 check("irq clear", {7'h00, irq}, 8'h00);
        wr(JOINT_CTRL_ADDR, 8'h90);
        pulse(0); check("held", {7'h00, envelope_out}, 8'h01);
        rd(IRQ_STATUS_ADDR); check("timeout still", rd_val, 8'h01);
        wr(IRQ_MASK_ADDR, 8'h00); repeat (2) @(posedge sys_clk);
        #1 check("masked", {7'h00, irq}, 8'h00);
        wr(IRQ_STATUS_ADDR, 8'h03);
        // clear and terminal count in one cycle: the event must stay flagged
        @(posedge sys_clk);
        reg_addr <= IRQ_STATUS_ADDR;
        reg_wdata <= 8'h01;
        reg_wr <= 1'b1;
        envelope_tc <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        envelope_tc <= 1'b0;
        rd(IRQ_STATUS_ADDR);
        check("set wins", rd_val, 8'h01);
        wr(IRQ_STATUS_ADDR, 8'h01);
        $display("test envelope done");
    endtask : test_envelope
    task automatic test_capture();
        wr(MODE_CTRL_ADDR, 8'h00); wr(JOINT_CTRL_ADDR, 8'h40);
        cap_cnt = 0; edges(2); check("transmit no capture", 8'(cap_cnt), 8'h00);
        wr_rd(MODE_CTRL_ADDR, 8'h80);
        check("mode rw", rd_val, 8'h80);
        cap_cnt = 0; edges(3); check("normal capture", 8'(cap_cnt), 8'h03);
        wr(IRQ_STATUS_ADDR, 8'h03);
        wr(JOINT_CTRL_ADDR, 8'h48); pulse(1);
        cap_cnt = 0; edges(3); check("active third", {7'h00, carrier_active}, 8'h01);
        check("none before fourth", 8'(cap_cnt), 8'h00);
        edges(1); rd(IRQ_STATUS_ADDR); check("no irq fourth", rd_val, 8'h00);
        edges(1); check("fourth fifth", 8'(cap_cnt), 8'h02);
        rd(IRQ_STATUS_ADDR); check("irq fifth", rd_val, 8'h02);
        edges(2); check("saturate", 8'(cap_cnt), 8'h02);
        pulse(1); check("count cleared", {7'h00, carrier_active}, 8'h00);
        cap_cnt = 0; edges(5); check("again", 8'(cap_cnt), 8'h02);
        $display("test capture done");
    endtask : test_capture
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0; stop_recovery = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 12'h000; reg_wdata = 8'h00; envelope_tc = 1'b0; carrier_tc = 1'b0;
        capture_pin = 1'b0; rd_val = 8'h00;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_regs();
        test_run_recovery();
        test_envelope();
        test_capture();
        stop_test();
    end
endmodule : timer_pair_ctrl_tb
